/* design/flash_sp_pkg.sv */
package flash_sp_pkg;

  // ****************************************
  // Flash geometry
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int FLASH_BYTES = 8192;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_LSB = 9;
  localparam int BOOT_UNIT_BYTES = 1024;
  localparam int BOOT_MAX_UNITS = 3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_OP_SELECT = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_DATA_BUF = 8'h0C;
  localparam logic [7:0] OFS_TRIGGER = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1C;

  // ****************************************
  // Operation codes and trigger keys
  // ****************************************
  localparam logic [7:0] OP_STANDBY = 8'h00;
  localparam logic [7:0] OP_READ = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h03;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'hB9;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BOOT_SEL_BIT = 6;
  localparam int CTRL_SOFT_RESET_TRIGGER_BIT = 5;
  localparam int CLK_SEL_W = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ****************************************
  // Status bits
  // ****************************************
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOADER_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_IGNORED_BIT = 3;

  // ****************************************
  // Option defaults and strap settling
  // ****************************************
  localparam logic [1:0] DEF_BOOT_UNITS = 2'h1;
  localparam logic [12:0] DEF_LOW_BOUND = 13'h1800;
  localparam logic DEF_LOCK = 1'b1;
  localparam logic [2:0] CFG_SETTLE = 3'h4;

  // ****************************************
  // Stall durations in flash clock ticks
  // ****************************************
  localparam int ERASE_TICKS_DEF = 600;
  localparam int PROG_TICKS_DEF = 32;
  localparam int READ_TICKS_DEF = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } op_state_t;

endpackage

/* design/strap_sync.sv */
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Accept a change only once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_o <= '0;
    end else if (ce_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule

/* design/flash_tick_gen.sv */
`timescale 1ns/1ps
module flash_tick_gen (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Control
  input wire logic run_i,
  input wire logic [flash_sp_pkg::CLK_SEL_W-1:0] sel_i,
  output logic tick_o
);
  logic [flash_sp_pkg::CLK_SEL_W-1:0] cnt_q;

  // One tick every sel_i + 1 system clocks
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_q <= '0;
        tick_o <= 1'b0;
      end else if (cnt_q >= sel_i) begin
        cnt_q <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick_o <= 1'b0;
      end
    end
  end
endmodule

/* design/flash_selfprog_boot_ctrl.sv */
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
// Operation
// - Loader code may alter application and data regions; application code only data region
// - Loader region size is a strap: off or 1K to 3K within 8K
// - Data region spans low bound up to just below loader start
// - Defaults: 1K loader, 1K data region, lock on; bound set by strap
// - Op select 03h erase, 02h program, 01h read
// - Program only clears bits; erase sets whole page to ones
// - Erase covers one 512-byte page aligned on nine low bits
// - Program writes data buffer to address from high and low bytes
// - Read places addressed flash byte into data buffer
// - Control bit 7 enables self-programming; software clears it afterwards
// - Five-bit clock select sets flash timing; 23 for 24MHz
// - Operation starts only after 46h then B9h to trigger port
// - Core stalls after valid trigger until operation fully completes
// - Control bits 7..5 = 001 soft resets into application at 0
// - Power-on boot option with loader region boots into loader
// - 101 from loader soft resets into application
// - 111 from application soft resets into loader, straps regardless
// - Bit 6 selects reboot region, bit 5 triggers soft reset
// - Reset into loader only when loader region size nonzero
// - Trigger outside permitted region is ignored: no operation, no stall
// - Interrupts pending during stall stay queued until completion
module flash_selfprog_boot_ctrl #(
  parameter int ERASE_TICKS = flash_sp_pkg::ERASE_TICKS_DEF,
  parameter int PROG_TICKS = flash_sp_pkg::PROG_TICKS_DEF,
  parameter int READ_TICKS = flash_sp_pkg::READ_TICKS_DEF,
  parameter int IRQ_W = 7
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Option straps
  input wire logic [1:0] boot_units_i,
  input wire logic [flash_sp_pkg::ADDR_W-1:0] data_region_low_bound_i,
  input wire logic power_on_boot_option_i,
  input wire logic alt_power_on_boot_option_i,
  // Core side
  input wire logic [IRQ_W-1:0] irq_i,
  output logic [IRQ_W-1:0] irq_o,
  output logic core_stall_o,
  output logic soft_reset_o,
  output logic run_loader_o
);

  localparam int CNT_W = $clog2(ERASE_TICKS + 1);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (ERASE_TICKS < flash_sp_pkg::PAGE_BYTES || PROG_TICKS < 1 || READ_TICKS < 1) begin : g_bad_ticks
    $error("Stall tick counts out of range");
  end
  if (PROG_TICKS > ERASE_TICKS || READ_TICKS > ERASE_TICKS) begin : g_bad_order
    $error("Erase must be the longest operation");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [13:0] boot_start(input logic [1:0] units);
    boot_start = 14'(flash_sp_pkg::FLASH_BYTES) - 14'(flash_sp_pkg::BOOT_UNIT_BYTES) * 14'(units);
  endfunction

  function automatic logic [15:0] op_ticks(input logic [7:0] op);
    case (op)
      flash_sp_pkg::OP_ERASE: op_ticks = 16'(ERASE_TICKS);
      flash_sp_pkg::OP_PROGRAM: op_ticks = 16'(PROG_TICKS);
      default: op_ticks = 16'(READ_TICKS);
    endcase
  endfunction

  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0] mem [flash_sp_pkg::FLASH_BYTES];
  logic [7:0] op_q;
  logic [7:0] ahi_q;
  logic [7:0] alo_q;
  logic [7:0] data_q;
  logic [7:0] ctrl_q;
  logic armed_q;
  logic ignored_q;
  logic [1:0] boot_units_q;
  logic [12:0] low_q;
  logic [2:0] settle_q;
  logic cfg_done_q;
  logic [12:0] addr_run_q;
  logic [7:0] op_run_q;
  logic [CNT_W-1:0] cnt_q;
  flash_sp_pkg::op_state_t state_q;
  logic tick;
  logic [16:0] strap_lvl;

  // ****************************************
  // Strap capture
  // ****************************************
  strap_sync #(
    .WIDTH(17)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .pin_i({alt_power_on_boot_option_i, power_on_boot_option_i, data_region_low_bound_i, boot_units_i}),
    .level_o(strap_lvl)
  );

  // Straps are read once after release so the map cannot shift mid-run
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      settle_q <= '0;
      cfg_done_q <= 1'b0;
      boot_units_q <= flash_sp_pkg::DEF_BOOT_UNITS;
      low_q <= flash_sp_pkg::DEF_LOW_BOUND;
    end else if (ce_i && !cfg_done_q) begin
      settle_q <= settle_q + 1'b1;
      if (settle_q == flash_sp_pkg::CFG_SETTLE) begin
        cfg_done_q <= 1'b1;
        boot_units_q <= (strap_lvl[1:0] > 2'(flash_sp_pkg::BOOT_MAX_UNITS)) ? 2'h0 : strap_lvl[1:0];
        low_q <= strap_lvl[14:2];
      end
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic access;
  logic mapped;
  logic wr_en;
  logic [7:0] rd_byte;

  assign access = psel_i && penable_i;
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= flash_sp_pkg::OFS_CONFIG);
  assign wr_en = access && pready_o && pwrite_i && !pslverr_o;

  always_comb begin
    rd_byte = 8'h00;
    case (paddr_i)
      flash_sp_pkg::OFS_OP_SELECT: rd_byte = op_q;
      flash_sp_pkg::OFS_ADDR_HIGH: rd_byte = ahi_q;
      flash_sp_pkg::OFS_ADDR_LOW: rd_byte = alo_q;
      flash_sp_pkg::OFS_DATA_BUF: rd_byte = data_q;
      flash_sp_pkg::OFS_CTRL: rd_byte = ctrl_q;
      flash_sp_pkg::OFS_STATUS: rd_byte = {4'h0, ignored_q, armed_q, run_loader_o, core_stall_o};
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (ce_i) begin
      pready_o <= access && !pready_o;
      pslverr_o <= access && !pready_o && !mapped;
      if (access && !pready_o) begin
        if (paddr_i == flash_sp_pkg::OFS_CONFIG) begin
          prdata_o <= {16'h0, flash_sp_pkg::DEF_LOCK, boot_units_q, low_q};
        end else begin
          prdata_o <= {24'h0, rd_byte};
        end
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      op_q <= flash_sp_pkg::OP_STANDBY;
      ahi_q <= 8'h00;
      alo_q <= 8'h00;
      ctrl_q <= flash_sp_pkg::CTRL_RST;
    end else if (ce_i && wr_en) begin
      case (paddr_i)
        flash_sp_pkg::OFS_OP_SELECT: op_q <= pwdata_i[7:0];
        flash_sp_pkg::OFS_ADDR_HIGH: ahi_q <= pwdata_i[7:0];
        flash_sp_pkg::OFS_ADDR_LOW: alo_q <= pwdata_i[7:0];
        // Reset trigger bit is a strobe and never stored
        flash_sp_pkg::OFS_CTRL: ctrl_q <= pwdata_i[7:0] & 8'hDF;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Trigger decode
  // ****************************************
  logic port_wr;
  logic key2_wr;
  logic [13:0] addr_full;
  logic [13:0] bstart;
  logic op_known;
  logic addr_ok;
  logic fire;

  assign port_wr = wr_en && (paddr_i == flash_sp_pkg::OFS_TRIGGER);
  assign key2_wr = port_wr && armed_q && (pwdata_i[7:0] == flash_sp_pkg::KEY_SECOND);
  assign addr_full = {ahi_q[5:0], alo_q};
  assign bstart = boot_start(boot_units_q);
  assign op_known = (op_q == flash_sp_pkg::OP_ERASE) || (op_q == flash_sp_pkg::OP_PROGRAM)
                    || (op_q == flash_sp_pkg::OP_READ);
  assign addr_ok = (ahi_q[7:6] == 2'h0) && (addr_full < bstart)
                   && (run_loader_o || (addr_full >= {1'b0, low_q}));
  assign fire = key2_wr && ctrl_q[flash_sp_pkg::CTRL_EN_BIT] && op_known && addr_ok
                && (state_q == flash_sp_pkg::ST_IDLE) && cfg_done_q;

  // Any port write other than the second key drops the sequence
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      armed_q <= 1'b0;
    end else if (ce_i && port_wr) begin
      armed_q <= !armed_q && (pwdata_i[7:0] == flash_sp_pkg::KEY_FIRST);
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ignored_q <= 1'b0;
    end else if (ce_i) begin
      if (key2_wr && !fire) begin
        ignored_q <= 1'b1;
      end else if (wr_en && paddr_i == flash_sp_pkg::OFS_STATUS) begin
        ignored_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  flash_tick_gen u_tick (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(state_q == flash_sp_pkg::ST_RUN),
    .sel_i(ctrl_q[flash_sp_pkg::CLK_SEL_W-1:0]),
    .tick_o(tick)
  );

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= flash_sp_pkg::ST_IDLE;
      cnt_q <= '0;
      op_run_q <= flash_sp_pkg::OP_STANDBY;
      addr_run_q <= '0;
      core_stall_o <= 1'b0;
    end else if (ce_i) begin
      case (state_q)
        flash_sp_pkg::ST_IDLE: begin
          if (fire) begin
            state_q <= flash_sp_pkg::ST_RUN;
            cnt_q <= '0;
            op_run_q <= op_q;
            addr_run_q <= addr_full[12:0];
            core_stall_o <= 1'b1;
          end
        end
        flash_sp_pkg::ST_RUN: begin
          if (tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (16'(cnt_q) == op_ticks(op_run_q) - 16'h1) begin
              state_q <= flash_sp_pkg::ST_DONE;
            end
          end
        end
        flash_sp_pkg::ST_DONE: begin
          state_q <= flash_sp_pkg::ST_IDLE;
          core_stall_o <= 1'b0;
        end
        default: begin
          state_q <= flash_sp_pkg::ST_IDLE;
          core_stall_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Flash array
  // ****************************************
  logic erase_step;
  assign erase_step = (state_q == flash_sp_pkg::ST_RUN) && tick && (op_run_q == flash_sp_pkg::OP_ERASE)
                      && (cnt_q < CNT_W'(flash_sp_pkg::PAGE_BYTES));

  // Erase walks its page one byte per tick; low address bits are forced
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (erase_step) begin
        mem[{addr_run_q[12:flash_sp_pkg::PAGE_LSB], cnt_q[8:0]}] <= flash_sp_pkg::ERASED_BYTE;
      end else if (state_q == flash_sp_pkg::ST_DONE && op_run_q == flash_sp_pkg::OP_PROGRAM) begin
        mem[addr_run_q] <= mem[addr_run_q] & data_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      data_q <= 8'h00;
    end else if (ce_i) begin
      if (state_q == flash_sp_pkg::ST_DONE && op_run_q == flash_sp_pkg::OP_READ) begin
        data_q <= mem[addr_run_q];
      end else if (wr_en && paddr_i == flash_sp_pkg::OFS_DATA_BUF) begin
        data_q <= pwdata_i[7:0];
      end
    end
  end

  // ****************************************
  // Boot region and soft reset
  // ****************************************
  logic soft_reset_trigger_wr;
  assign soft_reset_trigger_wr = wr_en && (paddr_i == flash_sp_pkg::OFS_CTRL) && pwdata_i[flash_sp_pkg::CTRL_SOFT_RESET_TRIGGER_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      run_loader_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else if (ce_i) begin
      soft_reset_o <= soft_reset_trigger_wr;
      if (!cfg_done_q && settle_q == flash_sp_pkg::CFG_SETTLE) begin
        run_loader_o <= (strap_lvl[15] || strap_lvl[16]) && (strap_lvl[1:0] != 2'h0)
                        && (strap_lvl[1:0] <= 2'(flash_sp_pkg::BOOT_MAX_UNITS));
      end else if (soft_reset_trigger_wr) begin
        // Loader target needs a real loader region, else reboot to application
        run_loader_o <= pwdata_i[flash_sp_pkg::CTRL_BOOT_SEL_BIT] && (boot_units_q != 2'h0);
      end
    end
  end

  // Interrupt lines are held back while stalled; level flags stay pending
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= '0;
    end else if (ce_i) begin
      irq_o <= core_stall_o ? '0 : irq_i;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_stall_on_fire: assert property (ce_i && fire |=> core_stall_o)
    else $error("Valid trigger did not stall the core");
  chk_ignore_no_stall: assert property (ce_i && key2_wr && !addr_ok && !core_stall_o |=> !core_stall_o)
    else $error("Out-of-region trigger caused a stall");
  chk_app_data_only: assert property (ce_i && fire && !run_loader_o |-> addr_full >= {1'b0, low_q})
    else $error("Application code reached outside data region");
  chk_key_order: assert property (fire |-> armed_q && $past(armed_q) && pwdata_i[7:0] == flash_sp_pkg::KEY_SECOND)
    else $error("Operation started without both keys");
  chk_opcode_decode: assert property (fire |-> op_known && op_q != flash_sp_pkg::OP_STANDBY)
    else $error("Operation started with unknown code");
  chk_soft_reset_trigger_pulse: assert property (ce_i && soft_reset_trigger_wr |=> soft_reset_o ##1 !soft_reset_o || !ce_i)
    else $error("Soft reset is not a single pulse");
  chk_loader_size: assert property ($rose(run_loader_o) |-> boot_units_q != 2'h0 || !cfg_done_q)
    else $error("Entered loader with no loader region");
  chk_stall_ends: assert property (ce_i && state_q == flash_sp_pkg::ST_DONE |=> !core_stall_o)
    else $error("Stall did not end after completion");
  chk_irq_held: assert property (ce_i && core_stall_o |=> irq_o == '0)
    else $error("Interrupt passed during stall");
  chk_apb_answer: assert property (ce_i && access && !pready_o |=> pready_o)
    else $error("APB access not answered");

  cov_erase: cover property (fire && op_q == flash_sp_pkg::OP_ERASE);
  cov_reset_loader: cover property (soft_reset_o && run_loader_o);
  cov_ignored: cover property ($rose(ignored_q));

endmodule

/* sim/core_model.sv */
`timescale 1ns/1ps
// ****************************************
// Core model: halts on stall, holds irq levels
// ****************************************
module core_model #(
  parameter int IRQ_W = 7
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Controller side
  input wire logic core_stall_i,
  input wire logic [IRQ_W-1:0] irq_seen_i,
  output logic [IRQ_W-1:0] irq_req_o,
  // Observations
  output int stall_len_o,
  output int stall_cnt_o,
  output int irq_leak_o
);
  int run_q;
  logic stall_q;

  // Level sources stay asserted through the halt, else they would be lost
  assign irq_req_o = IRQ_W'(8'h2A);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      run_q <= 0;
      stall_q <= 1'b0;
      stall_len_o <= 0;
      stall_cnt_o <= 0;
      irq_leak_o <= 0;
    end else begin
      stall_q <= core_stall_i;
      if (core_stall_i) begin
        run_q <= run_q + 1;
      end else if (run_q != 0) begin
        stall_len_o <= run_q;
        stall_cnt_o <= stall_cnt_o + 1;
        run_q <= 0;
      end
      // First stall cycle skipped: irq copy is registered
      if (core_stall_i && stall_q && irq_seen_i != '0) begin
        irq_leak_o <= irq_leak_o + 1;
      end
    end
  end
endmodule

/* sim/flash_selfprog_boot_ctrl_test.sv */
`timescale 1ns/1ps
module flash_selfprog_boot_ctrl_test;
  localparam int ERASE_N = 512;
  localparam int PROG_N = 2;
  localparam int READ_N = 2;
  logic sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, rerr;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic pready_o, pslverr_o, core_stall_o, soft_reset_o, run_loader_o;
  logic [1:0] boot_units_i;
  logic power_on_boot_option_i, alt_power_on_boot_option_i;
  logic [6:0] irq_i, irq_o;
  int errors = 0, tests_run = 0, cycles = 0, sr_cnt = 0, stall_len, stall_cnt, irq_leak;

  flash_selfprog_boot_ctrl #(.ERASE_TICKS(ERASE_N), .PROG_TICKS(PROG_N), .READ_TICKS(READ_N), .IRQ_W(7))
    i_flash_selfprog_boot_ctrl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .boot_units_i(boot_units_i),
    .data_region_low_bound_i(flash_sp_pkg::DEF_LOW_BOUND), .power_on_boot_option_i(power_on_boot_option_i),
    .alt_power_on_boot_option_i(alt_power_on_boot_option_i), .irq_i(irq_i), .irq_o(irq_o),
    .core_stall_o(core_stall_o), .soft_reset_o(soft_reset_o), .run_loader_o(run_loader_o));
  core_model #(.IRQ_W(7)) i_core_model (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .core_stall_i(core_stall_o), .irq_seen_i(irq_o), .irq_req_o(irq_i), .stall_len_o(stall_len),
    .stall_cnt_o(stall_cnt), .irq_leak_o(irq_leak));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (soft_reset_o === 1'b1) sr_cnt++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdata = prdata_o;
    rerr = pslverr_o;
    chk("pready", 32'h1, 32'(pready_o));
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic flash_op(input logic [7:0] op, input logic [12:0] a, input logic [7:0] d, input int n,
                          input logic [4:0] sel, input logic en, input logic brk);
    int c0, w;
    c0 = stall_cnt;
    w = 0;
    apb(1'b1, flash_sp_pkg::OFS_STATUS, 8'h00);
    apb(1'b1, flash_sp_pkg::OFS_CTRL, {en, 2'b00, sel});
    apb(1'b1, flash_sp_pkg::OFS_OP_SELECT, op);
    apb(1'b1, flash_sp_pkg::OFS_ADDR_HIGH, {3'b000, a[12:8]});
    apb(1'b1, flash_sp_pkg::OFS_ADDR_LOW, a[7:0]);
    apb(1'b1, flash_sp_pkg::OFS_DATA_BUF, d);
    apb(1'b1, flash_sp_pkg::OFS_TRIGGER, flash_sp_pkg::KEY_FIRST);
    if (brk) apb(1'b1, flash_sp_pkg::OFS_TRIGGER, 8'h00);
    apb(1'b1, flash_sp_pkg::OFS_TRIGGER, flash_sp_pkg::KEY_SECOND);
    while (n > 0 && stall_cnt == c0 && w < 3000) begin
      @(posedge sys_clk_i);
      w++;
    end
    apb(1'b0, flash_sp_pkg::OFS_STATUS, 8'h00);
    if (en && !brk) chk("ignored flag", 32'(n == 0), 32'(rdata[3]));
    chk("stall count", 32'(c0 + (n > 0)), 32'(stall_cnt));
    chk("stall level", 32'h0, 32'(core_stall_o));
    if (n > 0) chk("stall length", 32'h1, 32'(stall_len >= n * (sel + 1) && stall_len <= n * (sel + 1) + 4));
    chk("irq after stall", 32'(irq_i), 32'(irq_o));
    apb(1'b1, flash_sp_pkg::OFS_OP_SELECT, flash_sp_pkg::OP_STANDBY);
    apb(1'b1, flash_sp_pkg::OFS_CTRL, 8'h00);
  endtask

  task automatic read_byte(input logic [12:0] a, input logic [7:0] exp);
    flash_op(flash_sp_pkg::OP_READ, a, 8'h00, READ_N, 5'h00, 1'b1, 1'b0);
    apb(1'b0, flash_sp_pkg::OFS_DATA_BUF, 8'h00);
    chk("read byte", 32'(exp), rdata);
  endtask

  task automatic soft_rst(input logic [7:0] c, input logic exp);
    int s0;
    s0 = sr_cnt;
    apb(1'b1, flash_sp_pkg::OFS_CTRL, c);
    repeat (2) @(posedge sys_clk_i);
    chk("soft reset", 32'(s0 + 1), 32'(sr_cnt));
    chk("reboot region", 32'(exp), 32'(run_loader_o));
  endtask

  task automatic do_reset(input logic [1:0] u, input logic po, input logic alt, input logic exp);
    sys_rst_i <= 1'b1;
    boot_units_i <= u;
    power_on_boot_option_i <= po;
    alt_power_on_boot_option_i <= alt;
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Straps settle on the fifth edge after release
    repeat (8) @(posedge sys_clk_i);
    chk("boot region", 32'(exp), 32'(run_loader_o));
  endtask

  initial begin
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    boot_units_i = 2'h1;
    power_on_boot_option_i = 1'b0;
    alt_power_on_boot_option_i = 1'b0;
    @(posedge sys_clk_i);
    do_reset(2'h1, 1'b0, 1'b0, 1'b0);
    apb(1'b0, flash_sp_pkg::OFS_CONFIG, 8'h00);
    chk("config", {16'h0000, 1'b1, 2'h1, 13'h1800}, rdata);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", 32'h1, 32'(rerr));
    flash_op(flash_sp_pkg::OP_ERASE, 13'h1800, 8'h00, ERASE_N, 5'h00, 1'b1, 1'b0);
    read_byte(13'h19FF, 8'hFF);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1805, 8'hA5, PROG_N, 5'h00, 1'b1, 1'b0);
    read_byte(13'h1805, 8'hA5);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1805, 8'h5A, PROG_N, 5'h00, 1'b1, 1'b0);
    read_byte(13'h1805, 8'h00);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1806, 8'h3C, PROG_N, 5'h01, 1'b1, 1'b0);
    read_byte(13'h1806, 8'h3C);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h0100, 8'h00, 0, 5'h00, 1'b1, 1'b0);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1C00, 8'h00, 0, 5'h00, 1'b1, 1'b0);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h17FF, 8'h00, 0, 5'h00, 1'b1, 1'b0);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1807, 8'h00, 0, 5'h00, 1'b1, 1'b1);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1807, 8'h00, 0, 5'h00, 1'b0, 1'b0);
    soft_rst(8'hE0, 1'b1);
    flash_op(flash_sp_pkg::OP_ERASE, 13'h0000, 8'h00, ERASE_N, 5'h00, 1'b1, 1'b0);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h0100, 8'h99, PROG_N, 5'h00, 1'b1, 1'b0);
    read_byte(13'h0100, 8'h99);
    flash_op(flash_sp_pkg::OP_PROGRAM, 13'h1C00, 8'h00, 0, 5'h00, 1'b1, 1'b0);
    soft_rst(8'hA0, 1'b0);
    soft_rst(8'h20, 1'b0);
    do_reset(2'h0, 1'b1, 1'b0, 1'b0);
    soft_rst(8'hE0, 1'b0);
    do_reset(2'h3, 1'b0, 1'b1, 1'b1);
    chk("irq during stall", 32'h0, 32'(irq_leak));
    print_verdict();
  end
endmodule
